/* File: verilog/plac_pkg.sv */
// shared constants and types for the privilege level access checker
package plac_pkg;

   // ------------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int NUM_AREAS = 8;
   localparam int AREA_IDX_W = 3;
   localparam int NUM_LEVELS = 6;
   localparam int NUM_OPS = 4;
   localparam int PERM_W = 32;
   localparam int CFG_IDX_W = 8;

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      vendor_level,
      os_level_one,
      os_level_two,
      shared_app_level,
      app_level_one,
      app_level_two
   } plac_level_e;

   typedef enum logic [1:0] {
      op_read,
      op_write,
      op_delete,
      op_exec
   } plac_op_e;

   typedef enum logic {
      st_init,
      st_run
   } plac_state_e;

   // ------------------------------------------------------------------
   // configuration window in the core address space (word addresses)
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] CFG_BASE = 16'hff00;
   localparam logic [CFG_IDX_W-1:0] CFG_IDX_AREA_END = 8'h20;
   localparam logic [CFG_IDX_W-1:0] CFG_IDX_WRITERS = 8'h20;
   localparam logic [CFG_IDX_W-1:0] CFG_IDX_ISR_LEVEL = 8'h21;
   localparam int CFG_AREA_SEL_LSB = 2;
   localparam logic [1:0] CFG_W_BASE = 2'h0;
   localparam logic [1:0] CFG_W_LIMIT = 2'h1;
   localparam logic [1:0] CFG_W_PERM = 2'h2;
   localparam logic [1:0] CFG_W_OWNER = 2'h3;

   // ------------------------------------------------------------------
   // manufacturing defaults
   // ------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] DEF_AREA0_BASE = 16'h0000;
   localparam logic [ADDR_W-1:0] DEF_AREA0_LIMIT = 16'hfeff;
   localparam logic [PERM_W-1:0] DEF_AREA0_PERM = 32'h0000_00ff;
   localparam plac_level_e DEF_AREA0_OWNER = vendor_level;
   localparam logic [ADDR_W-1:0] DEF_OFF_BASE = 16'hffff;
   localparam logic [ADDR_W-1:0] DEF_OFF_LIMIT = 16'h0000;
   localparam logic [PERM_W-1:0] DEF_OFF_PERM = 32'h0000_0000;
   localparam logic [NUM_LEVELS-1:0] DEF_WRITERS = 6'h07;
   localparam plac_level_e DEF_ISR_LEVEL = os_level_one;
   localparam plac_level_e RESET_LEVEL = vendor_level;

endpackage

/* File: verilog/plac_checker.sv */
// area based memory access checker between processor core and memories
//
// Contract
// [R1] police read, write, delete, execute per level
// [R2] check code, data and cross-level jumps
// [R3] six independent privilege levels
// [R4] current level is subject of each decision
// [R5] decision uses target area and operation
// [R6] decide before access reaches memory
// [R7] refused access has no effect
// [R8] interrupt routines run at checked level
// [R9] attributes from defaults or software loads
// [R10] overriding defaults needs policy write permission
// [R11] attribute changes limited to authorised levels
// [R12] configuration registers are management interface
// [R13] denied access raises fault to core
// [R14] defaults loaded before first software access
`timescale 1ns/10ps
module plac_checker
   import plac_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic core_valid,
   input wire logic [plac_pkg::ADDR_W-1:0] core_addr,
   input wire plac_pkg::plac_op_e core_op,
   input wire logic [plac_pkg::DATA_W-1:0] core_wdata,
   input wire logic irq_enter,
   input wire logic irq_exit,
   output logic core_ready,
   output logic core_rvalid,
   output logic [plac_pkg::DATA_W-1:0] core_rdata,
   output logic core_fault,
   output logic [plac_pkg::ADDR_W-1:0] core_fault_addr,
   output plac_pkg::plac_level_e cur_level,
   output logic mem_valid,
   output logic [plac_pkg::ADDR_W-1:0] mem_addr,
   output plac_pkg::plac_op_e mem_op,
   output logic [plac_pkg::DATA_W-1:0] mem_wdata,
   input wire logic mem_rvalid,
   input wire logic [plac_pkg::DATA_W-1:0] mem_rdata
);
   import plac_pkg::*;

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   plac_state_e state_r, state_nxt;
   logic [AREA_IDX_W-1:0] init_cnt_r, init_cnt_nxt;
   logic [ADDR_W-1:0] base_r [NUM_AREAS];
   logic [ADDR_W-1:0] base_nxt [NUM_AREAS];
   logic [ADDR_W-1:0] limit_r [NUM_AREAS];
   logic [ADDR_W-1:0] limit_nxt [NUM_AREAS];
   logic [PERM_W-1:0] perm_r [NUM_AREAS];
   logic [PERM_W-1:0] perm_nxt [NUM_AREAS];
   plac_level_e owner_r [NUM_AREAS];
   plac_level_e owner_nxt [NUM_AREAS];
   logic [NUM_LEVELS-1:0] writers_r, writers_nxt;
   plac_level_e isr_level_r, isr_level_nxt;
   plac_level_e cur_r, cur_nxt;
   plac_level_e saved_r, saved_nxt;
   logic in_isr_r, in_isr_nxt;

   logic ready_r, ready_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [DATA_W-1:0] rdata_r, rdata_nxt;
   logic fault_r, fault_nxt;
   logic [ADDR_W-1:0] fault_addr_r, fault_addr_nxt;
   logic mvalid_r, mvalid_nxt;
   logic [ADDR_W-1:0] maddr_r, maddr_nxt;
   plac_op_e mop_r, mop_nxt;
   logic [DATA_W-1:0] mwdata_r, mwdata_nxt;

   // ------------------------------------------------------------------
   // area match, one comparator pair per area
   // ------------------------------------------------------------------
   logic [NUM_AREAS-1:0] area_hit;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_AREAS; gi++) begin : g_area
         assign area_hit[gi] = (core_addr >= base_r[gi]) && (core_addr <= limit_r[gi]); // [R5]
      end
   endgenerate

   // permission bit of a level for an operation: index is level*4 + op
   function automatic logic perm_ok(input logic [PERM_W-1:0] p, input plac_level_e l,
                                    input plac_op_e o);
      logic [4:0] idx;
      idx = {l, o};
      perm_ok = p[idx];
   endfunction

   // ------------------------------------------------------------------
   // access decision
   // ------------------------------------------------------------------
   logic is_cfg;
   logic [CFG_IDX_W-1:0] cfg_idx;
   logic [AREA_IDX_W-1:0] cfg_area;
   logic [1:0] cfg_word;
   logic sel_found;
   logic [AREA_IDX_W-1:0] sel_area;
   logic allowed;
   logic take;
   logic [DATA_W-1:0] cfg_rdata;
   plac_level_e tgt_owner;

   always_comb begin
      is_cfg = core_addr >= CFG_BASE;
      cfg_idx = core_addr[CFG_IDX_W-1:0];
      cfg_area = cfg_idx[CFG_AREA_SEL_LSB +: AREA_IDX_W];
      cfg_word = cfg_idx[1:0];
      take = (state_r == st_run) && core_valid; // [R14]
      // lowest numbered matching area wins
      sel_found = 1'b0;
      sel_area = '0;
      for (int i = NUM_AREAS - 1; i >= 0; i--) begin
         if (area_hit[i]) begin
            sel_found = 1'b1;
            sel_area = AREA_IDX_W'(i);
         end
      end
      tgt_owner = owner_r[sel_area];
      // configuration words are only visible to authorised levels
      if (is_cfg) begin
         allowed = writers_r[cur_r] && ((core_op == op_read) || (core_op == op_write)) &&
                   (cfg_idx < CFG_IDX_AREA_END || cfg_idx == CFG_IDX_WRITERS ||
                    cfg_idx == CFG_IDX_ISR_LEVEL); // [R11] [R10]
      end else begin
         // addresses outside every area are refused
         allowed = sel_found && perm_ok(perm_r[sel_area], cur_r, core_op); // [R1] [R2] [R4] [R5]
      end
      cfg_rdata = '0;
      if (cfg_idx == CFG_IDX_WRITERS) begin
         cfg_rdata[NUM_LEVELS-1:0] = writers_r;
      end else if (cfg_idx == CFG_IDX_ISR_LEVEL) begin
         cfg_rdata[2:0] = isr_level_r;
      end else begin
         unique case (cfg_word)
            CFG_W_BASE: cfg_rdata[ADDR_W-1:0] = base_r[cfg_area];
            CFG_W_LIMIT: cfg_rdata[ADDR_W-1:0] = limit_r[cfg_area];
            CFG_W_PERM: cfg_rdata = perm_r[cfg_area];
            CFG_W_OWNER: cfg_rdata[2:0] = owner_r[cfg_area];
         endcase
      end
   end

   // ------------------------------------------------------------------
   // attribute table and level tracking
   // ------------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      init_cnt_nxt = init_cnt_r;
      base_nxt = base_r;
      limit_nxt = limit_r;
      perm_nxt = perm_r;
      owner_nxt = owner_r;
      writers_nxt = writers_r;
      isr_level_nxt = isr_level_r;
      cur_nxt = cur_r;
      saved_nxt = saved_r;
      in_isr_nxt = in_isr_r;
      unique case (state_r)
         st_init: begin
            // manufacturing defaults, one area per cycle
            if (init_cnt_r == '0) begin
               base_nxt[init_cnt_r] = DEF_AREA0_BASE; // [R9] [R14]
               limit_nxt[init_cnt_r] = DEF_AREA0_LIMIT;
               perm_nxt[init_cnt_r] = DEF_AREA0_PERM;
               owner_nxt[init_cnt_r] = DEF_AREA0_OWNER;
            end else begin
               base_nxt[init_cnt_r] = DEF_OFF_BASE;
               limit_nxt[init_cnt_r] = DEF_OFF_LIMIT;
               perm_nxt[init_cnt_r] = DEF_OFF_PERM;
               owner_nxt[init_cnt_r] = DEF_AREA0_OWNER;
            end
            writers_nxt = DEF_WRITERS;
            isr_level_nxt = DEF_ISR_LEVEL;
            init_cnt_nxt = init_cnt_r + AREA_IDX_W'(1);
            if (init_cnt_r == AREA_IDX_W'(NUM_AREAS - 1)) begin
               state_nxt = st_run;
            end
         end
         st_run: begin
            if (take && allowed && is_cfg && core_op == op_write) begin
               // run-time load of permission control information
               if (cfg_idx == CFG_IDX_WRITERS) begin
                  writers_nxt = core_wdata[NUM_LEVELS-1:0]; // [R12] [R9]
               end else if (cfg_idx == CFG_IDX_ISR_LEVEL) begin
                  if (core_wdata[2:0] < 3'(NUM_LEVELS)) begin
                     isr_level_nxt = plac_level_e'(core_wdata[2:0]);
                  end
               end else begin
                  unique case (cfg_word)
                     CFG_W_BASE: base_nxt[cfg_area] = core_wdata[ADDR_W-1:0]; // [R12]
                     CFG_W_LIMIT: limit_nxt[cfg_area] = core_wdata[ADDR_W-1:0];
                     CFG_W_PERM: perm_nxt[cfg_area] = core_wdata;
                     CFG_W_OWNER: begin
                        // codes beyond the six levels are ignored
                        if (core_wdata[2:0] < 3'(NUM_LEVELS)) begin
                           owner_nxt[cfg_area] = plac_level_e'(core_wdata[2:0]); // [R3]
                        end
                     end
                  endcase
               end
            end
            // a permitted fetch into another level's area moves execution there
            if (take && allowed && !is_cfg && core_op == op_exec && tgt_owner != cur_r) begin
               cur_nxt = tgt_owner; // [R2] [R4]
            end
            // single nesting: a second entry overwrites the saved level
            if (irq_enter) begin
               saved_nxt = cur_nxt; // [R8]
               cur_nxt = isr_level_r; // [R8]
               in_isr_nxt = 1'b1;
            end else if (irq_exit && in_isr_r) begin
               cur_nxt = saved_r; // [R8]
               in_isr_nxt = 1'b0;
            end
         end
      endcase
   end

   // ------------------------------------------------------------------
   // core and memory side outputs
   // ------------------------------------------------------------------
   always_comb begin
      ready_nxt = (state_nxt == st_run); // [R14]
      mvalid_nxt = take && allowed && !is_cfg; // [R6] [R7]
      maddr_nxt = take ? core_addr : maddr_r;
      mop_nxt = take ? core_op : mop_r;
      // refused writes never carry their data towards memory
      mwdata_nxt = (take && allowed) ? core_wdata : mwdata_r; // [R7]
      fault_nxt = take && !allowed; // [R13]
      fault_addr_nxt = (take && !allowed) ? core_addr : fault_addr_r; // [R13]
      rvalid_nxt = 1'b0;
      rdata_nxt = rdata_r;
      if (take && allowed && is_cfg && core_op == op_read) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = cfg_rdata;
      end else if (mem_rvalid) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = mem_rdata;
      end
   end

   // ------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_r <= st_init;
         init_cnt_r <= '0;
         for (int i = 0; i < NUM_AREAS; i++) begin
            // deny everything until defaults are in
            base_r[i] <= DEF_OFF_BASE;
            limit_r[i] <= DEF_OFF_LIMIT;
            perm_r[i] <= DEF_OFF_PERM;
            owner_r[i] <= DEF_AREA0_OWNER;
         end
         writers_r <= '0;
         isr_level_r <= DEF_ISR_LEVEL;
         cur_r <= RESET_LEVEL;
         saved_r <= RESET_LEVEL;
         in_isr_r <= 1'b0;
         ready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         fault_r <= 1'b0;
         fault_addr_r <= '0;
         mvalid_r <= 1'b0;
         maddr_r <= '0;
         mop_r <= op_read;
         mwdata_r <= '0;
      end else begin
         state_r <= state_nxt;
         init_cnt_r <= init_cnt_nxt;
         base_r <= base_nxt;
         limit_r <= limit_nxt;
         perm_r <= perm_nxt;
         owner_r <= owner_nxt;
         writers_r <= writers_nxt;
         isr_level_r <= isr_level_nxt;
         cur_r <= cur_nxt;
         saved_r <= saved_nxt;
         in_isr_r <= in_isr_nxt;
         ready_r <= ready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         fault_r <= fault_nxt;
         fault_addr_r <= fault_addr_nxt;
         mvalid_r <= mvalid_nxt;
         maddr_r <= maddr_nxt;
         mop_r <= mop_nxt;
         mwdata_r <= mwdata_nxt;
      end
   end

   assign core_ready = ready_r;
   assign core_rvalid = rvalid_r;
   assign core_rdata = rdata_r;
   assign core_fault = fault_r;
   assign core_fault_addr = fault_addr_r;
   assign cur_level = cur_r;
   assign mem_valid = mvalid_r;
   assign mem_addr = maddr_r;
   assign mem_op = mop_r;
   assign mem_wdata = mwdata_r;

endmodule

/* File: tb/plac_checker_props.sv */
// concurrent checks on the ports of the access checker
`timescale 1ns/10ps
module plac_checker_props
   import plac_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic core_valid,
   input wire logic [plac_pkg::ADDR_W-1:0] core_addr,
   input wire plac_pkg::plac_op_e core_op,
   input wire logic [plac_pkg::DATA_W-1:0] core_wdata,
   input wire logic irq_enter,
   input wire logic irq_exit,
   input wire logic core_ready,
   input wire logic core_rvalid,
   input wire logic [plac_pkg::DATA_W-1:0] core_rdata,
   input wire logic core_fault,
   input wire logic [plac_pkg::ADDR_W-1:0] core_fault_addr,
   input wire plac_pkg::plac_level_e cur_level,
   input wire logic mem_valid,
   input wire logic [plac_pkg::ADDR_W-1:0] mem_addr,
   input wire plac_pkg::plac_op_e mem_op,
   input wire logic [plac_pkg::DATA_W-1:0] mem_wdata,
   input wire logic mem_rvalid,
   input wire logic [plac_pkg::DATA_W-1:0] mem_rdata
);
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic take;
   assign take = core_ready && core_valid;
   // saturates so the init window is only judged once per reset
   always_comb begin
      cnt_nxt = (cnt_r == 4'hf) ? cnt_r : cnt_r + 4'h1;
   end
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_r <= 4'h0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_ready_after_init: assert property (core_ready == (cnt_r >= 4'h8))
      else $error("ready not raised after eight load cycles");
   a_answer_exactly_one: assert property (
      take && core_addr < CFG_BASE |=> mem_valid != core_fault)
      else $error("memory request not answered by exactly one of forward or fault");
   a_fault_addr_kept: assert property (
      core_fault |-> $past(take) && core_fault_addr == $past(core_addr))
      else $error("fault address does not match refused request");
   a_mem_follows_req: assert property (
      mem_valid |-> $past(take) && mem_addr == $past(core_addr) && mem_op == $past(core_op))
      else $error("forwarded request differs from taken request");
   a_idle_is_quiet: assert property (!take |=> !mem_valid && !core_fault)
      else $error("answer without a taken request");
   a_fault_no_effect: assert property (core_fault |-> !mem_valid && $stable(mem_wdata))
      else $error("refused request reached memory side");
   a_rdata_echoed: assert property (mem_rvalid && !(take && core_addr >= CFG_BASE)
      |=> core_rvalid && core_rdata == $past(mem_rdata))
      else $error("memory read data not echoed to core");
   a_fault_keeps_level: assert property (
      core_fault && !$past(irq_enter) && !$past(irq_exit) |-> $stable(cur_level))
      else $error("level changed by refused request");
endmodule

bind plac_checker plac_checker_props u_props (.clk, .reset, .core_valid, .core_addr, .core_op,
   .core_wdata, .irq_enter, .irq_exit, .core_ready, .core_rvalid, .core_rdata, .core_fault,
   .core_fault_addr, .cur_level, .mem_valid, .mem_addr, .mem_op, .mem_wdata, .mem_rvalid,
   .mem_rdata);

/* File: tb/plac_mem_model.sv */
// memory model answering requests forwarded by the access checker
`timescale 1ns/10ps
module plac_mem_model
   import plac_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [1:0] lat,
   input wire logic mem_valid,
   input wire logic [plac_pkg::ADDR_W-1:0] mem_addr,
   input wire plac_pkg::plac_op_e mem_op,
   input wire logic [plac_pkg::DATA_W-1:0] mem_wdata,
   output logic mem_rvalid,
   output logic [plac_pkg::DATA_W-1:0] mem_rdata
);
   logic [DATA_W-1:0] store [0:255];
   logic [DATA_W-1:0] last_r;
   logic [7:0] ra_r;
   logic [1:0] wait_r;
   logic busy_r;
   // between answers the data lines carry the inverse, never a stale copy
   assign mem_rdata = mem_rvalid ? last_r : ~last_r;
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         busy_r <= 1'b0;
         mem_rvalid <= 1'b0;
         last_r <= 32'h0;
      end else begin
         mem_rvalid <= 1'b0;
         if (mem_valid && mem_op == op_write) begin
            store[mem_addr[7:0]] <= mem_wdata;
         end
         if (mem_valid && mem_op == op_delete) begin
            store[mem_addr[7:0]] <= 32'h0;
         end
         if (mem_valid && mem_op == op_read) begin
            busy_r <= 1'b1;
            wait_r <= lat;
            ra_r <= mem_addr[7:0];
         end else if (busy_r && wait_r != 2'h0) begin
            wait_r <= wait_r - 2'h1;
         end else if (busy_r) begin
            busy_r <= 1'b0;
            mem_rvalid <= 1'b1;
            last_r <= store[ra_r];
         end
      end
   end
endmodule

/* File: tb/plac_checker_bench.sv */
// self-checking bench for the privilege level access checker
`timescale 1ns/10ps
module plac_checker_bench;
   import plac_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic core_valid = 1'b0;
   logic [ADDR_W-1:0] core_addr = 16'h0010;
   plac_op_e core_op = op_read;
   logic [DATA_W-1:0] core_wdata = 32'h0;
   logic irq_enter = 1'b0;
   logic irq_exit = 1'b0;
   logic [1:0] lat = 2'h0;
   logic core_ready, core_rvalid, core_fault, mem_valid, mem_rvalid;
   logic [DATA_W-1:0] core_rdata, mem_wdata, mem_rdata;
   logic [ADDR_W-1:0] core_fault_addr, mem_addr;
   plac_level_e cur_level;
   plac_op_e mem_op;
   int n_mismatch = 0;
   int cmp_count = 0;

   always #5 clk = ~clk;

   plac_checker u_dut (.clk, .reset, .core_valid, .core_addr, .core_op, .core_wdata, .irq_enter,
      .irq_exit, .core_ready, .core_rvalid, .core_rdata, .core_fault, .core_fault_addr,
      .cur_level, .mem_valid, .mem_addr, .mem_op, .mem_wdata, .mem_rvalid, .mem_rdata);
   plac_mem_model u_mem (.clk, .reset, .lat, .mem_valid, .mem_addr, .mem_op, .mem_wdata,
      .mem_rvalid, .mem_rdata);

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // one request held across one rising edge, answer judged after it
   task automatic req(input logic [15:0] a, input plac_op_e op, input logic [31:0] d,
         input logic ok);
      logic [1:0] e;
      e = ok ? {a < CFG_BASE, 1'b0} : 2'b01;
      // an idle edge first, so core_valid never drops and rises in one time step
      @(negedge clk);
      core_valid = 1'b1;
      core_addr = a;
      core_op = op;
      core_wdata = d;
      @(negedge clk);
      core_valid = 1'b0;
      chk(32'({mem_valid, core_fault}), 32'(e));
      if (e == 2'b10) begin
         chk(32'({mem_addr, mem_op}), 32'({a, op}));
      end
      if (!ok) begin
         chk(32'(core_fault_addr), 32'(a));
      end
   endtask

   task automatic rd_wait(input logic [31:0] d);
      int i;
      for (i = 0; i < 20 && core_rvalid !== 1'b1; i++) begin
         @(negedge clk);
      end
      if (i == 20) begin
         n_mismatch++;
         $display("MISMATCH at %0t: read answer missing", $time);
         finish_test();
      end else begin
         chk(core_rdata, d);
      end
   endtask

   task automatic pulse(input logic enter);
      irq_enter = enter;
      irq_exit = !enter;
      @(negedge clk);
      irq_enter = 1'b0;
      irq_exit = 1'b0;
   endtask

   task automatic t_init();
      chk(32'({core_ready, mem_valid, core_fault, cur_level}), 32'h0);
      core_valid = 1'b1;
      reset = 1'b0;
      for (int k = 1; k <= 8; k++) begin
         @(negedge clk);
         chk(32'({core_ready, mem_valid}), 32'({k == 8, 1'b0}));
      end
      core_valid = 1'b0;
      @(negedge clk);
      chk(32'(mem_valid), 32'h0);
      $display("t_init done");
   endtask

   task automatic t_vendor();
      req(16'h0010, op_write, 32'h0000_00a5, 1'b1);
      req(16'h0010, op_read, 32'h0, 1'b1);
      rd_wait(32'h0000_00a5);
      req(16'h0010, op_delete, 32'h0, 1'b1);
      req(16'h0010, op_exec, 32'h0, 1'b1);
      chk(32'(cur_level), 32'(vendor_level));
      $display("t_vendor done");
   endtask

   task automatic t_config();
      // lowest area wins, so area 0 is shrunk before area 1 can own 0x0100
      req(16'hff01, op_write, 32'h0000_00ff, 1'b1);
      req(16'hff21, op_write, 32'h0000_0007, 1'b1);
      req(16'hff21, op_read, 32'h0, 1'b1);
      chk(32'({core_rvalid, core_rdata[30:0]}), 32'h8000_0001);
      req(16'hff20, op_write, 32'h0000_0003, 1'b1);
      req(16'hff20, op_read, 32'h0, 1'b1);
      chk(32'({core_rvalid, core_rdata[30:0]}), 32'h8000_0003);
      req(16'hff04, op_write, 32'h0000_0100, 1'b1);
      req(16'hff05, op_write, 32'h0000_01ff, 1'b1);
      req(16'hff06, op_write, 32'h0009_000f, 1'b1);
      req(16'hff07, op_write, 32'(app_level_one), 1'b1);
      req(16'hff06, op_read, 32'h0, 1'b1);
      chk({core_rdata[31:1], core_rvalid}, 32'h0009_000f);
      req(16'hff30, op_read, 32'h0, 1'b0);
      req(16'hff06, op_exec, 32'h0, 1'b0);
      req(16'h0100, op_write, 32'h5a5a_0001, 1'b1);
      req(16'h0100, op_exec, 32'h0, 1'b1);
      chk(32'(cur_level), 32'(app_level_one));
      $display("t_config done");
   endtask

   task automatic t_app();
      req(16'h0100, op_read, 32'h0, 1'b1);
      rd_wait(32'h5a5a_0001);
      req(16'h0100, op_write, 32'hdead_0000, 1'b0);
      req(16'h0010, op_read, 32'h0, 1'b0);
      req(16'hff06, op_write, 32'hffff_ffff, 1'b0);
      req(16'h0100, op_delete, 32'h0, 1'b0);
      chk(32'(cur_level), 32'(app_level_one));
      $display("t_app done");
   endtask

   task automatic t_irq();
      pulse(1'b1);
      chk(32'(cur_level), 32'(os_level_one));
      lat = 2'h3;
      req(16'h0010, op_read, 32'h0, 1'b1);
      rd_wait(32'h0);
      lat = 2'h0;
      core_valid = 1'b1;
      core_op = op_write;
      core_addr = 16'h0010;
      core_wdata = 32'h77;
      @(negedge clk);
      chk(32'({mem_valid, mem_addr}), 32'h0001_0010);
      chk(mem_wdata, 32'h0000_0077);
      core_addr = 16'h0012;
      @(negedge clk);
      core_valid = 1'b0;
      chk(32'({mem_valid, mem_addr}), 32'h0001_0012);
      pulse(1'b0);
      chk(32'(cur_level), 32'(app_level_one));
      req(16'h0010, op_read, 32'h0, 1'b0);
      $display("t_irq done");
   endtask

   initial begin
      repeat (3) @(negedge clk);
      t_init();
      t_vendor();
      t_config();
      t_app();
      t_irq();
      finish_test();
   end
endmodule
